// ### core/pdmcap_pkg.sv
// shared constants and types for the digital microphone capture block
package pdmcap_pkg;

    // microphone bit clock and system clock rates
    localparam int unsigned SYS_CLK_FREQ_KHZ = 10000;  // core clock, 10 MHz
    localparam int unsigned MIC_CLK_FREQ_KHZ = 2048;   // default mic clock, 2.048MHz
    // the divider toggles the pin twice per mic clock period
    localparam int unsigned TOGGLE_RATE_KHZ  = 2 * MIC_CLK_FREQ_KHZ;
    localparam int unsigned NCO_WIDTH        = 15;     // holds sums below 2 x 10000

    // filter sizes
    localparam int unsigned CIC_WIDTH        = 20;     // holds +-2^18 for ratio 512
    localparam int unsigned PCM_WIDTH        = 16;     // width of one pcm channel

    // decimation ratio selection: ratio is 2^(RATE_LOG2_BASE + sel)
    localparam int unsigned RATE_SEL_WIDTH   = 2;
    localparam int unsigned RATE_LOG2_BASE   = 6;      // sel 0 gives ratio 64
    localparam logic [1:0]  RATE_SEL_RESET   = 2'h0;   // 32 kHz at 2.048 MHz
    localparam int unsigned DECIM_CNT_WIDTH  = 9;      // counts up to 511

    // reset values
    localparam logic        MIC_CLK_RESET    = 1'b0;   // clock idles low at reset

    // one stereo pcm sample handed to the audio link
    typedef struct packed {
        logic signed [PCM_WIDTH-1:0] left;   // left, rising-edge channel
        logic signed [PCM_WIDTH-1:0] right;  // right, falling-edge channel
    } pdmcap_pcm_t;

endpackage

// ### core/pdmcap_cic.sv
`timescale 1ns/1ps
// second order cic decimator turning one 1-bit stream into wide samples
module pdmcap_cic
    import pdmcap_pkg::*;
#(
    parameter int unsigned WIDTH = CIC_WIDTH
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    bit_en,
    input  wire logic                    bit_val,
    input  wire logic                    dump_en,
    output logic signed [WIDTH-1:0]      sample
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic signed [WIDTH-1:0] int1_reg,  int1_next;   // first integrator
    logic signed [WIDTH-1:0] int2_reg,  int2_next;   // second integrator
    logic signed [WIDTH-1:0] dly1_reg,  dly1_next;   // first comb delay
    logic signed [WIDTH-1:0] dly2_reg,  dly2_next;   // second comb delay
    logic signed [WIDTH-1:0] out_reg,   out_next;    // last decimated sample
    logic signed [WIDTH-1:0] comb1;                  // first comb difference
    logic signed [WIDTH-1:0] in_val;                 // bit mapped to +1 / -1

    ////////////////////////////////////////////////////////////////////////////
    // integrators run at the bit rate, combs at the decimated rate
    always_comb begin
        in_val    = bit_val ? WIDTH'(1) : -WIDTH'(1);
        int1_next = int1_reg;
        int2_next = int2_reg;
        dly1_next = dly1_reg;
        dly2_next = dly2_reg;
        out_next  = out_reg;
        comb1     = int2_reg - dly1_reg;
        // integrate each new bit; wrap-around is harmless for a cic
        if (bit_en) begin
            int1_next = int1_reg + in_val;
            int2_next = int2_reg + int1_reg;
        end
        // comb stages at the sample boundary
        if (dump_en) begin
            dly1_next = int2_reg;
            dly2_next = comb1;
            out_next  = comb1 - dly2_reg;
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int1_reg <= '0;
            int2_reg <= '0;
            dly1_reg <= '0;
            dly2_reg <= '0;
            out_reg  <= '0;
        end else begin
            int1_reg <= int1_next;
            int2_reg <= int2_next;
            dly1_reg <= dly1_next;
            dly2_reg <= dly2_next;
            out_reg  <= out_next;
        end
    end

    assign sample = out_reg;

endmodule

// ### core/pdmcap_capture.sv
`timescale 1ns/1ps
// digital microphone front end: clock generator, edge capture, decimation, pcm out

// How it works
// R01 - we drive the mic bit clock ourselves
// R02 - clock runs at 2.048MHz from reset
// R03 - mono or stereo on one data pin
// R04 - left bit taken at rising clock edge
// R05 - right bit taken at falling clock edge
// R06 - microphones drive 1-bit data with clock
// R07 - each stream filtered into multi-bit pcm
// R08 - pcm samples forwarded toward audio link
// R09 - decimation ratio sets output sample rate
// R10 - mono copies left into both channels
module pdmcap_capture
    import pdmcap_pkg::*;
#(
    parameter int unsigned SYS_KHZ = SYS_CLK_FREQ_KHZ,   // core clock rate
    parameter int unsigned MIC_KHZ = MIC_CLK_FREQ_KHZ    // mic clock rate
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      stereo_mode,
    input  wire logic [RATE_SEL_WIDTH-1:0] rate_sel,
    input  wire logic                      mic_data,
    output logic                           mic_clk,
    output pdmcap_pcm_t                    pcm,
    output logic                           pcm_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // constants derived from the rates
    localparam logic [NCO_WIDTH-1:0] NCO_INC = NCO_WIDTH'(2 * MIC_KHZ);  // toggle step
    localparam logic [NCO_WIDTH-1:0] NCO_MOD = NCO_WIDTH'(SYS_KHZ);      // wrap point
    localparam int unsigned          WIDE    = CIC_WIDTH + 3;            // scaled width

    ////////////////////////////////////////////////////////////////////////////
    // functions
    // log2 of the decimation ratio for a rate selection
    function automatic logic [3:0] ratio_log2(input logic [RATE_SEL_WIDTH-1:0] sel);
        ratio_log2 = 4'(RATE_LOG2_BASE) + 4'(sel);
    endfunction

    // scale a cic sample of gain ratio^2 to full-scale pcm, saturating
    function automatic logic signed [PCM_WIDTH-1:0] to_pcm(input logic signed [CIC_WIDTH-1:0] v,
                                                          input logic [3:0] lg);
        logic signed [WIDE-1:0] w;
        logic [4:0]             sh;
        w  = {v, 3'h0};
        sh = 5'({lg, 1'b0} - 5'h0c);
        w  = w >>> sh;
        if (w > WIDE'(16'sh7fff)) begin
            to_pcm = 16'sh7fff;
        end else if (w < -WIDE'(16'sh7fff) - WIDE'(1)) begin
            to_pcm = -16'sh7fff - 16'sh0001;
        end else begin
            to_pcm = w[PCM_WIDTH-1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mic clock generator: fractional divider, one toggle enable per half period
    logic [NCO_WIDTH-1:0] nco_reg,     nco_next;      // phase accumulator
    logic                 mic_clk_reg, mic_clk_next;  // driven clock level
    logic                 rise_ev,     fall_ev;       // edge being made this cycle
    logic [NCO_WIDTH-1:0] nco_sum;                    // accumulator plus step
    // edge events are delayed by the two sync flops, so a capture sees the pin
    // as it stood at the clock edge itself, not two cycles before it
    logic [1:0]           rise_pipe_reg, rise_pipe_next;  // rise event delay line
    logic [1:0]           fall_pipe_reg, fall_pipe_next;  // fall event delay line
    logic                 cap_rise;                       // take left bit now
    logic                 cap_fall;                       // take right bit now

    always_comb begin
        nco_sum      = nco_reg + NCO_INC;
        nco_next     = nco_sum;
        mic_clk_next = mic_clk_reg;
        rise_ev      = 1'b0;
        fall_ev      = 1'b0;
        // wrap and toggle the clock pin [R01] [R02]
        if (nco_sum >= NCO_MOD) begin
            nco_next     = nco_sum - NCO_MOD;
            mic_clk_next = ~mic_clk_reg;
            rise_ev      = ~mic_clk_reg;
            fall_ev      = mic_clk_reg;
        end
        // line the edge events up with the synchronised pin [R04] [R05]
        rise_pipe_next = {rise_pipe_reg[0], rise_ev};
        fall_pipe_next = {fall_pipe_reg[0], fall_ev};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nco_reg       <= '0;
            mic_clk_reg   <= MIC_CLK_RESET;
            rise_pipe_reg <= '0;
            fall_pipe_reg <= '0;
        end else begin
            nco_reg       <= nco_next;
            mic_clk_reg   <= mic_clk_next;
            rise_pipe_reg <= rise_pipe_next;
            fall_pipe_reg <= fall_pipe_next;
        end
    end

    // capture strobes: pin value sampled at the edge that made the mic clock change
    assign cap_rise = rise_pipe_reg[1];
    assign cap_fall = fall_pipe_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // data pin synchroniser, two flops before any logic
    logic data_meta_reg;   // first stage, read only by the second
    logic data_sync_reg;   // safe copy of the pin

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_meta_reg <= 1'b0;
            data_sync_reg <= 1'b0;
        end else begin
            data_meta_reg <= mic_data;
            data_sync_reg <= data_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decimation counter and rate latch
    logic [DECIM_CNT_WIDTH-1:0] dec_cnt_reg, dec_cnt_next;    // rising edges so far
    logic [RATE_SEL_WIDTH-1:0]  rate_reg,    rate_next;       // active rate
    logic [DECIM_CNT_WIDTH-1:0] dec_last;                     // last count of a frame
    logic                       dump;                         // sample boundary
    logic                       dump_dly_reg, dump_dly_next;  // cic output ready

    always_comb begin
        dec_last      = DECIM_CNT_WIDTH'((10'h001 << ratio_log2(rate_reg)) - 10'h001);
        dec_cnt_next  = dec_cnt_reg;
        rate_next     = rate_reg;
        dump          = 1'b0;
        dump_dly_next = 1'b0;
        // count mic clock periods; ratio = mic rate / sample rate [R09]
        if (cap_rise) begin
            if (dec_cnt_reg == dec_last) begin
                dec_cnt_next  = '0;
                dump          = 1'b1;
                dump_dly_next = 1'b1;
                // rate changes only at a sample boundary
                rate_next     = rate_sel;
            end else begin
                dec_cnt_next  = dec_cnt_reg + DECIM_CNT_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_cnt_reg  <= '0;
            rate_reg     <= RATE_SEL_RESET;
            dump_dly_reg <= 1'b0;
        end else begin
            dec_cnt_reg  <= dec_cnt_next;
            rate_reg     <= rate_next;
            dump_dly_reg <= dump_dly_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel filters; microphones present data in step with our clock [R06]
    logic signed [CIC_WIDTH-1:0] left_raw;    // left decimated sample
    logic signed [CIC_WIDTH-1:0] right_raw;   // right decimated sample
    logic [3:0]                  used_lg;     // ratio of the finished sample

    // left bit taken as the clock rises [R04] [R07]
    pdmcap_cic #(
        .WIDTH   (CIC_WIDTH)
    ) u_left (
        .clk     (clk),
        .sys_rst (sys_rst),
        .bit_en  (cap_rise),
        .bit_val (data_sync_reg),
        .dump_en (dump),
        .sample  (left_raw)
    );

    // right bit taken as the clock falls, same pin [R05] [R03] [R07]
    pdmcap_cic #(
        .WIDTH   (CIC_WIDTH)
    ) u_right (
        .clk     (clk),
        .sys_rst (sys_rst),
        .bit_en  (cap_fall),
        .bit_val (data_sync_reg),
        .dump_en (dump),
        .sample  (right_raw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pcm output stage toward the link
    pdmcap_pcm_t pcm_reg,       pcm_next;        // held stereo sample
    logic        pcm_valid_reg, pcm_valid_next;  // one-cycle strobe
    logic [3:0]  lg_reg,        lg_next;         // ratio used by the sample in flight

    always_comb begin
        used_lg        = lg_reg;
        lg_next        = dump ? ratio_log2(rate_reg) : lg_reg;
        pcm_next       = pcm_reg;
        pcm_valid_next = 1'b0;
        // hand each finished sample to the link [R08]
        if (dump_dly_reg) begin
            pcm_valid_next = 1'b1;
            pcm_next.left  = to_pcm(left_raw, used_lg);
            // mono copies left to both channels [R10] [R03]
            pcm_next.right = stereo_mode ? to_pcm(right_raw, used_lg) : to_pcm(left_raw, used_lg);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pcm_reg       <= '0;
            pcm_valid_reg <= 1'b0;
            lg_reg        <= 4'(RATE_LOG2_BASE);
        end else begin
            pcm_reg       <= pcm_next;
            pcm_valid_reg <= pcm_valid_next;
            lg_reg        <= lg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign mic_clk   = mic_clk_reg;
    assign pcm       = pcm_reg;
    assign pcm_valid = pcm_valid_reg;

endmodule

// ### bench/pdmcap_capture_monitor.sv
// concurrent checks on the capture block ports
`timescale 1ns/1ps
module pdmcap_capture_monitor
    import pdmcap_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic                      stereo_mode,
    input wire logic [RATE_SEL_WIDTH-1:0] rate_sel,
    input wire logic                      mic_data,
    input wire logic                      mic_clk,
    input wire pdmcap_pcm_t               pcm,
    input wire logic                      pcm_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [11:0] gap_reg;   // cycles since last strobe
    logic [11:0] gap_next;  // next gap count
    ////////////////////////////////////////////////////////////////
    // saturating strobe gap counter
    always_comb begin
        gap_next = pcm_valid ? 12'h000 : ((gap_reg == 12'hfff) ? gap_reg : gap_reg + 12'h001);
    end
    always_ff @(posedge clk) begin
        gap_reg <= sys_rst ? 12'h000 : gap_next;
    end
    ////////////////////////////////////////////////////////////////
    // assertions
    AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=> !mic_clk && !pcm_valid && pcm == '0)
        else $error("outputs not idle after reset");
    AST_HIGH_MIN: assert property ($rose(mic_clk) |=> mic_clk)
        else $error("clock high too short");
    AST_HIGH_MAX: assert property ($rose(mic_clk) |-> ##[2:3] $fell(mic_clk))
        else $error("clock high too long");
    AST_LOW_MIN: assert property ($fell(mic_clk) |=> !mic_clk)
        else $error("clock low too short");
    AST_LOW_MAX: assert property ($fell(mic_clk) |-> ##[2:3] $rose(mic_clk))
        else $error("clock low too long");
    AST_VALID_PULSE: assert property (pcm_valid |=> !pcm_valid)
        else $error("strobe longer than one cycle");
    AST_PCM_HOLD: assert property (!pcm_valid |-> $stable(pcm))
        else $error("pcm changed without strobe");
    AST_MONO_COPY: assert property (pcm_valid && !$past(stereo_mode) |-> pcm.left == pcm.right)
        else $error("mono channels differ");
    AST_GAP_MIN: assert property (pcm_valid |-> gap_reg >= 12'h0fa)
        else $error("strobes too close");
    AST_GAP_MAX: assert property (gap_reg < 12'hb00)
        else $error("strobes too far apart");
endmodule
bind pdmcap_capture pdmcap_capture_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .stereo_mode(stereo_mode),
    .rate_sel(rate_sel), .mic_data(mic_data), .mic_clk(mic_clk), .pcm(pcm), .pcm_valid(pcm_valid));

// ### bench/pdmcap_mic_model.sv
// behavioural pair of microphones sharing one data pin
`timescale 1ns/1ps
module pdmcap_mic_model (
    input  wire logic mic_clk,
    input  wire logic left_bit,
    input  wire logic right_bit,
    input  wire logic right_on,
    output logic      mic_data
);
    initial mic_data = 1'b0;
    // left mic drives after the falling edge, ready for the rise
    always @(negedge mic_clk) #20 mic_data = left_bit;
    // right mic drives after the rise; absent mic leaves a changing line
    always @(posedge mic_clk) #20 mic_data = right_on ? right_bit : ~mic_data;
endmodule

// ### bench/pdm_mic_capture_tb.sv
// self-checking bench for the capture block
`timescale 1ns/1ps
module pdm_mic_capture_tb;
    import pdmcap_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, stereo_mode = 1'b1, mic_data, mic_clk, pcm_valid;
    logic [1:0] rate_sel = 2'h0;
    logic left_bit = 1'b1, right_bit = 1'b0, right_on = 1'b1;
    pdmcap_pcm_t pcm;
    int num_errors = 0, compares = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////
    // design and partner
    pdmcap_capture i_dut (.clk(clk), .sys_rst(sys_rst), .stereo_mode(stereo_mode), .rate_sel(rate_sel),
        .mic_data(mic_data), .mic_clk(mic_clk), .pcm(pcm), .pcm_valid(pcm_valid));
    pdmcap_mic_model i_mic (.mic_clk(mic_clk), .left_bit(left_bit), .right_bit(right_bit),
        .right_on(right_on), .mic_data(mic_data));
    initial forever #50 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pcm_valid !== 1'b1 && n < 3000);
        chk({31'h0, pcm_valid}, 32'h1);
    endtask
    task automatic summarize();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        repeat (16) @(negedge clk);
        chk({30'h0, mic_clk, pcm_valid}, 32'h0);
        chk(pcm, 32'h0);
        sys_rst = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_rate();
        int rises;
        logic prev;
        rises = 0;
        prev = mic_clk;
        repeat (10000) begin
            @(posedge clk);
            #1;
            if (mic_clk && !prev) rises++;
            prev = mic_clk;
        end
        chk({31'h0, rises >= 2047 && rises <= 2049}, 32'h1);
        $display("test rate done, %0d rises", rises);
    endtask
    task automatic t_mode(input logic st, input logic lb, input logic rb, input logic [31:0] exp);
        @(negedge clk);
        stereo_mode = st;
        right_on = st;
        left_bit = lb;
        right_bit = rb;
        // the comb spans two frames, so skip any sample that saw old bits
        repeat (4) wait_valid();
        chk(pcm, exp);
        $display("test mode done");
    endtask
    task automatic t_ratio(input logic [1:0] sel);
        int rises;
        logic prev;
        @(negedge clk);
        rate_sel = sel;
        repeat (3) wait_valid();
        rises = 0;
        prev = mic_clk;
        do begin
            @(posedge clk);
            #1;
            if (mic_clk && !prev) rises++;
            prev = mic_clk;
        end while (pcm_valid !== 1'b1 && rises < 600);
        chk(rises, 32'h1 << (RATE_LOG2_BASE + sel));
        $display("test ratio %0d done", sel);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        t_reset();
        t_rate();
        t_mode(1'b1, 1'b1, 1'b0, 32'h7fff8000);
        t_mode(1'b1, 1'b0, 1'b1, 32'h80007fff);
        t_mode(1'b0, 1'b1, 1'b0, 32'h7fff7fff);
        for (int s = 0; s < 4; s++) t_ratio(s[1:0]);
        summarize();
    end
endmodule
